// *** common/ftdr_pkg.sv ***
// Shared constants for the fan tachometer and duty register bank.
package ftdr_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int TIMEBASE_NS   = 10000;
    localparam int TICK_CYCLES   = TIMEBASE_NS / CLK_PERIOD_NS;
    localparam int PWM_PRESCALE  = 4;

    // ------------------------------------------------------------
    // Register indices; the byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CONFIG_TWO   = 8'h02;
    localparam logic [7:0] IDX_FAULT_DUTY   = 8'h03;
    localparam logic [7:0] IDX_LIMIT_HIGH   = 8'h0E;
    localparam logic [7:0] IDX_LIMIT_LOW    = 8'h0F;
    localparam logic [7:0] IDX_USER_FIRST   = 8'h10;
    localparam logic [7:0] IDX_USER_LAST    = 8'h17;
    localparam logic [7:0] IDX_LUT_FIRST    = 8'h20;
    localparam logic [7:0] IDX_LUT_LAST     = 8'h4F;
    localparam logic [7:0] IDX_DIRECT_DUTY  = 8'h50;
    localparam logic [7:0] IDX_PRESENT_DUTY = 8'h51;
    localparam logic [7:0] IDX_FAN1_HIGH    = 8'h52;
    localparam logic [7:0] IDX_FAN1_LOW     = 8'h53;

    // ------------------------------------------------------------
    // Values after reset and field positions
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_CONFIG_TWO   = 8'h00;
    localparam logic [7:0]  RST_FAULT_DUTY   = 8'hFF;
    localparam logic [7:0]  RST_LIMIT_HIGH   = 8'hFF;
    localparam logic [7:0]  RST_LIMIT_LOW    = 8'hFE;
    localparam logic [7:0]  RST_USER         = 8'h00;
    localparam logic [7:0]  RST_LUT          = 8'hFF;
    localparam logic [7:0]  RST_DIRECT_DUTY  = 8'hFF;
    localparam logic [7:0]  RST_PRESENT_DUTY = 8'h00;
    localparam logic [15:0] RST_FAN1_COUNT   = 16'h0000;
    localparam logic [15:0] COUNT_MAX        = 16'hFFFF;
    localparam int          DIRECT_SEL_BIT   = 0;
    localparam int          USER_BYTES       = 8;
    localparam int          LUT_BYTES        = 48;

endpackage

// *** rtl/ftdr_tach_meter.sv ***
// Tachometer period meter: counts timebase ticks between tach rising edges.
`timescale 1ns/1ns
module ftdr_tach_meter #(
    parameter int TICK_CYCLES = ftdr_pkg::TICK_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        tach_in,
    output logic             tick,
    output logic [15:0]      count
);
    import ftdr_pkg::*;

    // ------------------------------------------------------------
    // Timebase and period counter
    // ------------------------------------------------------------
    logic [15:0] div_reg;
    logic [15:0] run_reg;
    logic        tach_d_reg;
    logic [15:0] count_reg;
    logic        tick_reg;

    wire         div_end = (div_reg == 16'(TICK_CYCLES - 1));
    wire         rise    = tach_in & ~tach_d_reg;
    wire         run_sat = (run_reg == COUNT_MAX);

    // One tick every TICK_CYCLES clocks gives the count its time unit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg  <= 16'h0000;
            tick_reg <= 1'b0;
        end else begin
            div_reg  <= div_end ? 16'h0000 : div_reg + 16'h0001;
            tick_reg <= div_end;
        end
    end

    // The whole 16-bit result is updated at once, so halves never mix.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tach_d_reg <= 1'b0;
            run_reg    <= 16'h0000;
            count_reg  <= RST_FAN1_COUNT;
        end else begin
            tach_d_reg <= tach_in;
            // A tick landing on the edge opens the new period, so no tick is lost.
            if (rise) begin
                count_reg <= run_reg;
                run_reg   <= tick_reg ? 16'h0001 : 16'h0000;
            end else if (tick_reg && !run_sat) begin
                run_reg <= run_reg + 16'h0001;
            end else if (run_sat) begin
                count_reg <= COUNT_MAX; // A stalled fan shows the slowest reading.
            end
        end
    end

    assign tick  = tick_reg;
    assign count = count_reg;
endmodule

// *** rtl/ftdr_regs.sv ***
// Fan tachometer limit, user storage, duty lookup and duty register bank on APB.
//
// Local design decision: register access over APB.
`timescale 1ns/1ns

// How it works
// - Limit high byte at index 0Eh, read/write, resets to FFh.
// - Limit low byte at index 0Fh, read/write, resets to FEh.
// - Limit is a 16-bit tick count; larger means slower fan.
// - Eight user bytes at indices 10h to 17h, reset to 00h.
// - Forty-eight lookup bytes at 20h to 4Fh, reset to FFh.
// - With direct select set and no fan failure, duty comes from byte 50h, reset FFh.
// - Read-only byte 51h always shows the duty being driven, reset 00h.
// - Read-only byte 52h holds fan count high byte, reset 00h.
// - Count is the number of ten-microsecond ticks between tach rising edges.
// - Read-only byte 53h holds the fan count low byte frozen at the last read of 52h.
// - On fan failure the duty comes from fault duty byte 03h.
module ftdr_regs #(
    parameter int TICK_CYCLES  = ftdr_pkg::TICK_CYCLES,
    parameter int PWM_PRESCALE = ftdr_pkg::PWM_PRESCALE
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        fan1_speed_input,
    input  wire logic [5:0]  lut_index,
    output logic             pwm_out,
    output logic             fan_fail
);
    import ftdr_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic in_range(input logic [7:0] idx, input logic [7:0] lo, input logic [7:0] hi);
        in_range = (idx >= lo) && (idx <= hi);
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]  config_two_reg;
    logic [7:0]  fault_duty_reg;
    logic [7:0]  tach_limit_high_reg;
    logic [7:0]  tach_limit_low_reg;
    logic [7:0]  direct_duty_reg;
    logic [7:0]  present_duty_reg;
    logic [7:0]  fan1_low_snap_reg;
    logic [7:0]  user_mem [USER_BYTES];
    logic [7:0]  lut_mem [LUT_BYTES];
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        fan_fail_reg;
    logic        pwm_out_reg;
    logic [7:0]  pwm_cnt_reg;
    logic [7:0]  pre_cnt_reg;
    logic [7:0]  rd_byte;
    logic        rd_hit;
    logic [7:0]  duty_next;
    logic        tick;
    logic [15:0] fan1_count;

    // ------------------------------------------------------------
    // Tachometer measurement
    // ------------------------------------------------------------
    ftdr_tach_meter #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tach (
        .pclk    (pclk),
        .presetn (presetn),
        .tach_in (fan1_speed_input),
        .tick    (tick),
        .count   (fan1_count)
    );

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire [7:0]  idx        = paddr[9:2];
    wire        idx_ok     = (paddr[11:10] == 2'b00);
    wire        setup      = psel & ~penable;
    wire        wr_en      = psel & penable & pready_reg & pwrite & ~pslverr_reg;
    wire        is_user    = idx_ok && in_range(idx, IDX_USER_FIRST, IDX_USER_LAST);
    wire        is_lut     = idx_ok && in_range(idx, IDX_LUT_FIRST, IDX_LUT_LAST);
    wire [2:0]  user_off   = 3'(idx - IDX_USER_FIRST);
    wire [5:0]  lut_off    = 6'(idx - IDX_LUT_FIRST);
    wire [15:0] limit      = {tach_limit_high_reg, tach_limit_low_reg};
    wire        direct_sel = config_two_reg[DIRECT_SEL_BIT];
    wire        lut_ok     = (lut_index < 6'(LUT_BYTES));
    wire [7:0]  auto_duty  = lut_ok ? lut_mem[lut_index] : RST_LUT;
    wire        pre_end    = (pre_cnt_reg == 8'(PWM_PRESCALE - 1));

    // Read mux; an unmapped index reads zero and raises pslverr.
    always_comb begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        if (!idx_ok) begin
            rd_hit = 1'b0;
        end else if (idx == IDX_CONFIG_TWO) begin
            rd_byte = config_two_reg;
        end else if (idx == IDX_FAULT_DUTY) begin
            rd_byte = fault_duty_reg;
        end else if (idx == IDX_LIMIT_HIGH) begin
            rd_byte = tach_limit_high_reg;
        end else if (idx == IDX_LIMIT_LOW) begin
            rd_byte = tach_limit_low_reg;
        end else if (is_user) begin
            rd_byte = user_mem[user_off];
        end else if (is_lut) begin
            rd_byte = lut_mem[lut_off];
        end else if (idx == IDX_DIRECT_DUTY) begin
            rd_byte = direct_duty_reg;
        end else if (idx == IDX_PRESENT_DUTY) begin
            rd_byte = present_duty_reg;
        end else if (idx == IDX_FAN1_HIGH) begin
            rd_byte = fan1_count[15:8];
        end else if (idx == IDX_FAN1_LOW) begin
            rd_byte = fan1_low_snap_reg;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // APB answer: pready rises in the first access cycle, no waits.
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg  <= setup;
            pslverr_reg <= setup & ~rd_hit;
            if (setup && !pwrite) begin
                prdata_reg <= {24'h00_0000, rd_byte};
            end
        end
    end

    // Reading the high count byte freezes the low byte for the next read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fan1_low_snap_reg <= RST_FAN1_COUNT[7:0];
        end else if (setup && !pwrite && idx_ok && idx == IDX_FAN1_HIGH) begin
            fan1_low_snap_reg <= fan1_count[7:0];
        end
    end

    // ------------------------------------------------------------
    // Writable registers; the nonvolatile ones reload factory values
    // at reset because no backing store is modelled here.
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_two_reg      <= RST_CONFIG_TWO;
            fault_duty_reg      <= RST_FAULT_DUTY;
            tach_limit_high_reg <= RST_LIMIT_HIGH;
            tach_limit_low_reg  <= RST_LIMIT_LOW;
            direct_duty_reg     <= RST_DIRECT_DUTY;
        end else if (wr_en) begin
            if (idx == IDX_CONFIG_TWO) begin
                config_two_reg <= pwdata[7:0];
            end else if (idx == IDX_FAULT_DUTY) begin
                fault_duty_reg <= pwdata[7:0];
            end else if (idx == IDX_LIMIT_HIGH) begin
                tach_limit_high_reg <= pwdata[7:0];
            end else if (idx == IDX_LIMIT_LOW) begin
                tach_limit_low_reg <= pwdata[7:0];
            end else if (idx == IDX_DIRECT_DUTY) begin
                direct_duty_reg <= pwdata[7:0];
            end
        end
    end

    // User bytes and lookup table share one write path.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < USER_BYTES; i++) begin
                user_mem[i] <= RST_USER;
            end
            for (int i = 0; i < LUT_BYTES; i++) begin
                lut_mem[i] <= RST_LUT;
            end
        end else if (wr_en && is_user) begin
            user_mem[user_off] <= pwdata[7:0];
        end else if (wr_en && is_lut) begin
            lut_mem[lut_off] <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // Fan failure and duty selection; failure overrides every mode.
    // ------------------------------------------------------------
    assign duty_next = fan_fail_reg ? fault_duty_reg :
                       direct_sel   ? direct_duty_reg : auto_duty;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fan_fail_reg     <= 1'b0;
            present_duty_reg <= RST_PRESENT_DUTY;
        end else begin
            fan_fail_reg     <= (fan1_count > limit);
            present_duty_reg <= duty_next;
        end
    end

    // ------------------------------------------------------------
    // PWM generator. The duty is taken linearly; a full byte still
    // leaves one low slot in 256, traded for a simple comparator.
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt_reg <= 8'h00;
            pwm_cnt_reg <= 8'h00;
            pwm_out_reg <= 1'b0;
        end else begin
            pre_cnt_reg <= pre_end ? 8'h00 : pre_cnt_reg + 8'h01;
            if (pre_end) begin
                pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
            end
            pwm_out_reg <= (pwm_cnt_reg < present_duty_reg);
        end
    end

    assign prdata   = prdata_reg;
    assign pready   = pready_reg;
    assign pslverr  = pslverr_reg;
    assign pwm_out  = pwm_out_reg;
    assign fan_fail = fan_fail_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [15:0] tick_gap_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_gap_reg <= 16'hFFFF; // One below zero, so the first tick sees the full spacing.
        end else begin
            tick_gap_reg <= tick ? 16'h0000 : tick_gap_reg + 16'h0001;
        end
    end

    AST_LIMIT_HIGH_WRITE: assert property (
        wr_en && idx == IDX_LIMIT_HIGH |=> tach_limit_high_reg == $past(pwdata[7:0]))
        else $error("limit high byte did not take the written value");
    AST_LIMIT_LOW_WRITE: assert property (
        wr_en && idx == IDX_LIMIT_LOW |=> tach_limit_low_reg == $past(pwdata[7:0]))
        else $error("limit low byte did not take the written value");
    AST_FAIL_CAUSE: assert property (
        presetn |=> fan_fail_reg == ($past(fan1_count) > $past(limit)))
        else $error("fan failure flag does not match count against limit");
    AST_FAULT_DUTY: assert property (
        fan_fail_reg |=> present_duty_reg == $past(fault_duty_reg))
        else $error("failing fan is not driven with the fault duty");
    AST_DIRECT_DUTY: assert property (
        !fan_fail_reg && direct_sel ##1 $stable(direct_duty_reg) |-> present_duty_reg == direct_duty_reg)
        else $error("direct mode does not drive the direct duty");
    AST_PRESENT_DUTY: assert property (
        presetn |=> present_duty_reg == $past(duty_next))
        else $error("present duty lags the driven duty");
    AST_SNAP_LOW: assert property (
        setup && !pwrite && idx_ok && idx == IDX_FAN1_HIGH |=> fan1_low_snap_reg == $past(fan1_count[7:0]))
        else $error("low count byte not frozen with high byte read");
    AST_HIGH_READ: assert property (
        setup && !pwrite && idx_ok && idx == IDX_FAN1_HIGH |=> prdata_reg == {24'h00_0000, $past(fan1_count[15:8])})
        else $error("high count byte read returned wrong data");
    AST_TICK_SPACING: assert property (
        tick |-> tick_gap_reg == 16'(TICK_CYCLES - 1))
        else $error("timebase tick spacing is wrong");
    AST_PREADY_ONE: assert property (
        setup |=> pready_reg ##1 !pready_reg)
        else $error("pready not a single access cycle");

    COV_FAN_FAIL:  cover property (!fan_fail_reg ##1 fan_fail_reg);
    COV_DIRECT:    cover property (wr_en && idx == IDX_DIRECT_DUTY ##[1:4] present_duty_reg == direct_duty_reg);
    COV_LUT_WRITE: cover property (wr_en && is_lut);
    COV_UNMAPPED:  cover property (pready_reg && pslverr_reg);
endmodule

// *** dv/ftdr_fan_model.sv ***
// Fan model: drives tachometer rising edges at a programmable spacing.
`timescale 1ns/1ns
module ftdr_fan_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [15:0] period,
    output logic             tach,
    output logic [15:0]      edges
);
    logic [15:0] cnt_reg;

    // One rising edge every period clocks, high for the first half.
    // A zero period parks the rotor, so the line rests low.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 16'h0000;
            tach    <= 1'b0;
            edges   <= 16'h0000;
        end else if (period == 16'h0000) begin
            tach <= 1'b0;
        end else if (cnt_reg >= period - 16'h0001) begin
            cnt_reg <= 16'h0000;
            tach    <= 1'b1;
            edges   <= edges + 16'h0001;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
            tach    <= (cnt_reg < (period >> 1));
        end
    end
endmodule

// *** dv/tb_fan_tach_duty_registers.sv ***
// Self-checking bench for the fan tachometer and duty register bank.
`timescale 1ns/1ns
module tb_fan_tach_duty_registers;
    import ftdr_pkg::*;
    localparam int TB_TICK = 4;
    logic        pclk      = 1'b0;
    logic        presetn   = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [11:0] paddr     = 12'h000;
    logic [31:0] pwdata    = 32'h00000000;
    logic [5:0]  lut_index = 6'h00;
    logic [15:0] period    = 16'h0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tach;
    logic        pwm_out;
    logic        fan_fail;
    logic [15:0] edges;
    logic [31:0] rd;
    logic        err;
    int          n_errors   = 0;
    int          n_compared = 0;
    int          hi;

    // Half period of 25 ns gives the 20 MHz bus clock.
    always #25 pclk = ~pclk;

    ftdr_regs #(.TICK_CYCLES(TB_TICK), .PWM_PRESCALE(1)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fan1_speed_input(tach), .lut_index(lut_index), .pwm_out(pwm_out), .fan_fail(fan_fail)
    );

    ftdr_fan_model fan (.pclk(pclk), .presetn(presetn), .period(period), .tach(tach), .edges(edges));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // One APB transfer; the request holds until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                       output logic [31:0] rv, output logic ev);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rv = prdata;
        ev = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            check(32'h0, 32'h1, "bus answer timeout");
            results();
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, {2'b00, idx, 2'b00}, d, rd, err);
        check({31'h0, err}, 32'h0, "write error flag");
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, {2'b00, idx, 2'b00}, 8'h00, rd, err);
        check(rd, {24'h000000, exp}, "read data");
        check({31'h0, err}, 32'h0, "read error flag");
    endtask

    // Bounded wait for a number of tachometer edges from the fan model.
    task automatic wait_edges(input int n);
        logic [15:0] target;
        int          k;
        target = edges + 16'(n);
        k = 0;
        while (edges !== target && k < 20000) begin
            @(posedge pclk);
            k++;
        end
        if (k >= 20000) begin
            check(32'h0, 32'h1, "fan edge timeout");
            results();
        end
    endtask

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // Factory values, with the fan parked.
        rdc(IDX_LIMIT_HIGH, RST_LIMIT_HIGH);
        rdc(IDX_LIMIT_LOW, RST_LIMIT_LOW);
        for (int i = 0; i < USER_BYTES; i++) rdc(IDX_USER_FIRST + 8'(i), RST_USER);
        for (int i = 0; i < LUT_BYTES; i++) rdc(IDX_LUT_FIRST + 8'(i), RST_LUT);
        rdc(IDX_DIRECT_DUTY, RST_DIRECT_DUTY);
        rdc(IDX_FAULT_DUTY, RST_FAULT_DUTY);
        rdc(IDX_PRESENT_DUTY, RST_LUT);
        rdc(IDX_FAN1_HIGH, 8'h00);
        rdc(IDX_FAN1_LOW, 8'h00);
        $display("test reset values done");
        // Limit, user and lookup bytes keep what was written; the last lookup byte is 4Fh.
        wr(IDX_LIMIT_HIGH, 8'h12);
        wr(IDX_LIMIT_LOW, 8'h34);
        rdc(IDX_LIMIT_HIGH, 8'h12);
        rdc(IDX_LIMIT_LOW, 8'h34);
        for (int i = 0; i < USER_BYTES; i++) wr(IDX_USER_FIRST + 8'(i), 8'hA0 + 8'(i));
        for (int i = 0; i < USER_BYTES; i++) rdc(IDX_USER_FIRST + 8'(i), 8'hA0 + 8'(i));
        for (int i = 0; i < LUT_BYTES; i++) wr(IDX_LUT_FIRST + 8'(i), 8'h40 + 8'(i));
        for (int i = 0; i < LUT_BYTES; i++) rdc(IDX_LUT_FIRST + 8'(i), 8'h40 + 8'(i));
        rdc(IDX_LUT_LAST, 8'h6F);
        $display("test read write done");
        // Automatic duty follows the selected lookup byte; out of range gives FFh.
        lut_index <= 6'd5;
        rdc(IDX_PRESENT_DUTY, 8'h45);
        lut_index <= 6'd50;
        rdc(IDX_PRESENT_DUTY, 8'hFF);
        // Direct mode drives the output from the direct byte.
        wr(IDX_CONFIG_TWO, 8'h01);
        wr(IDX_DIRECT_DUTY, 8'h40);
        rdc(IDX_DIRECT_DUTY, 8'h40);
        rdc(IDX_PRESENT_DUTY, 8'h40);
        hi = 0;
        repeat (256) begin
            @(posedge pclk);
            if (pwm_out === 1'b1) hi++;
        end
        check(32'(hi), 32'd64, "pwm high cycles");
        // Read-only bytes ignore writes without an error.
        wr(IDX_PRESENT_DUTY, 8'h11);
        wr(IDX_FAN1_HIGH, 8'h77);
        rdc(IDX_PRESENT_DUTY, 8'h40);
        rdc(IDX_FAN1_HIGH, 8'h00);
        // Unmapped places answer with an error, read zero and drop writes.
        apb(1'b0, 12'h180, 8'h00, rd, err);
        check({err, rd[30:0]}, 32'h80000000, "unmapped read");
        apb(1'b1, 12'h438, 8'h99, rd, err);
        check({31'h0, err}, 32'h1, "unmapped write");
        rdc(IDX_LIMIT_HIGH, 8'h12);
        $display("test duty and access done");
        // Fan spinning at 20 ticks per edge, then slowed to 300.
        period <= 16'(TB_TICK * 20);
        wait_edges(3);
        rdc(IDX_FAN1_HIGH, 8'h00);
        rdc(IDX_FAN1_LOW, 8'h14);
        check({31'h0, fan_fail}, 32'h0, "fan fail fast");
        rdc(IDX_FAN1_HIGH, 8'h00);
        period <= 16'(TB_TICK * 300);
        wait_edges(3);
        rdc(IDX_FAN1_LOW, 8'h14);
        rdc(IDX_FAN1_HIGH, 8'h01);
        rdc(IDX_FAN1_LOW, 8'h2C);
        $display("test tach count done");
        // Limit equal to the count is not a failure; one below is.
        wr(IDX_FAULT_DUTY, 8'h20);
        rdc(IDX_FAULT_DUTY, 8'h20);
        wr(IDX_LIMIT_HIGH, 8'h01);
        wr(IDX_LIMIT_LOW, 8'h2C);
        repeat (3) @(posedge pclk);
        check({31'h0, fan_fail}, 32'h0, "fan fail at limit");
        rdc(IDX_PRESENT_DUTY, 8'h40);
        wr(IDX_LIMIT_LOW, 8'h2B);
        repeat (3) @(posedge pclk);
        check({31'h0, fan_fail}, 32'h1, "fan fail above limit");
        rdc(IDX_PRESENT_DUTY, 8'h20);
        // Speeding up again clears the failure and restores direct duty.
        period <= 16'(TB_TICK * 20);
        wait_edges(3);
        check({31'h0, fan_fail}, 32'h0, "fan fail cleared");
        rdc(IDX_PRESENT_DUTY, 8'h40);
        $display("test fan failure done");
        results();
    end
endmodule
